// ===== common/ftg_params.svh
`ifndef FTG_PARAMS_SVH
`define FTG_PARAMS_SVH

// ----------------------------------------
// Register offsets (word addresses)
// ----------------------------------------
`define FTG_ADDR_LOW_WORD 8'h00
`define FTG_ADDR_HIGH_WORD 8'h01
`define FTG_ADDR_PULL_RANGE 8'h02

// ----------------------------------------
// Field positions and widths
// ----------------------------------------
`define FTG_WORD_W 26
`define FTG_LOW_W 16
`define FTG_HIGH_W 10
`define FTG_GATE_BIT 10
`define FTG_RANGE_W 4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define FTG_LOW_RESET 16'h0000
`define FTG_HIGH_RESET 10'h000
`define FTG_GATE_RESET 1'b0
`define FTG_RANGE_RESET 4'h0

`endif

// ===== common/ftg_pkg.sv
package ftg_pkg;

	// Source of the output enable decision
	typedef enum logic {
		FTG_OE_HW,
		FTG_OE_SW
	} ftg_oe_src_t;

	typedef logic [15:0] ftg_reg_t;

endpackage

// ===== rtl/ftg_regs.sv
`timescale 1ns/1ns
`include "ftg_params.svh"

module ftg_regs #(
	parameter int WORD_W = `FTG_WORD_W
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [7:0] addr,
	input wire logic [15:0] wdata,
	input wire logic sw_oe_mode,
	input wire logic oe_pin,
	output logic [15:0] rdata,
	output logic rvalid,
	output logic signed [WORD_W-1:0] pull_setting_word,
	output logic word_update,
	output logic [3:0] pull_range,
	output logic out_enable
);

	// ----------------------------------------
	// Decode and packing helpers
	// ----------------------------------------
	// Word address match, shared by the write strobes and the read mux
	function automatic logic addr_hit(
		input logic [7:0] a,
		input logic [7:0] target
	);
		return a == target;
	endfunction

	// High-word read image; unused top bits are tied low in this one place
	function automatic logic [15:0] high_image(
		input logic gate,
		input logic [`FTG_HIGH_W-1:0] field
	);
		return {5'h00, gate, field};
	endfunction

	// Pull-range read image; only the four code bits exist
	function automatic logic [15:0] range_image(
		input logic [`FTG_RANGE_W-1:0] code
	);
		return {12'h000, code};
	endfunction

	// Offset word from its two halves; the cast pins the width to the port
	function automatic logic signed [WORD_W-1:0] join_word(
		input logic [`FTG_HIGH_W-1:0] hi,
		input logic [`FTG_LOW_W-1:0] lo
	);
		return WORD_W'({hi, lo});
	endfunction

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [1:0] oe_pin_sync;
	logic [1:0] mode_sync;

	// Two flops each; only the second stage is read
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			oe_pin_sync <= 2'b00;
			mode_sync <= 2'b00;
		end else begin
			oe_pin_sync <= {oe_pin_sync[0], oe_pin};
			mode_sync <= {mode_sync[0], sw_oe_mode};
		end
	end

	// Enable source follows the synchronised mode pin only
	ftg_pkg::ftg_oe_src_t oe_src;
	logic sw_ctrl;
	assign oe_src = mode_sync[1] ? ftg_pkg::FTG_OE_SW : ftg_pkg::FTG_OE_HW;
	assign sw_ctrl = (oe_src == ftg_pkg::FTG_OE_SW);

	// ----------------------------------------
	// Register storage
	// ----------------------------------------
	logic [`FTG_LOW_W-1:0] low_word;
	logic [`FTG_HIGH_W-1:0] high_word;
	logic out_gate;
	logic wr_low;
	logic wr_high;
	logic wr_range;

	// Write strobes per register; unmapped addresses match none of them
	assign wr_low = wr_en && addr_hit(addr, `FTG_ADDR_LOW_WORD);
	assign wr_high = wr_en && addr_hit(addr, `FTG_ADDR_HIGH_WORD);
	assign wr_range = wr_en && addr_hit(addr, `FTG_ADDR_PULL_RANGE);

	// Low word is only staged; it has no effect on the output by itself
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			low_word <= `FTG_LOW_RESET;
		end else if (wr_low) begin
			low_word <= wdata[`FTG_LOW_W-1:0];
		end
	end

	// High word; bits 15:11 are not stored, so writes there vanish
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			high_word <= `FTG_HIGH_RESET;
		end else if (wr_high) begin
			high_word <= wdata[`FTG_HIGH_W-1:0];
		end
	end

	// Gate bit only takes writes while enable is under software control
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			out_gate <= `FTG_GATE_RESET;
		end else if (wr_high && sw_ctrl) begin
			out_gate <= wdata[`FTG_GATE_BIT];
		end
	end

	// Pull range scales the word; real range table lives in the analog trim
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pull_range <= `FTG_RANGE_RESET;
		end else if (wr_range) begin
			pull_range <= wdata[`FTG_RANGE_W-1:0];
		end
	end

	// ----------------------------------------
	// Commit of the offset word
	// ----------------------------------------
	// Next committed word: staged low half joined to the high half on the bus
	logic signed [WORD_W-1:0] next_pull_setting_word;

	always_comb begin
		next_pull_setting_word = pull_setting_word;
		if (wr_high) begin
			next_pull_setting_word = join_word(wdata[`FTG_HIGH_W-1:0], low_word);
		end
	end

	// Both halves land on one edge, so the tuner never sees a half-updated word
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pull_setting_word <= '0;
		end else begin
			// Signed; full scale maps to the range end linearly
			pull_setting_word <= next_pull_setting_word;
		end
	end

	// Commit strobe; a low-word write alone never raises it
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			word_update <= 1'b0;
		end else begin
			word_update <= wr_high;
		end
	end

	// ----------------------------------------
	// Output driver gate
	// ----------------------------------------
	// Registered, so the driver sees a gate write one cycle after the bit lands
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			out_enable <= 1'b0;
		end else if (sw_ctrl) begin
			out_enable <= out_gate;
		end else begin
			out_enable <= oe_pin_sync[1];
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	// Read mux; unmapped addresses read zero
	logic [15:0] next_rdata;

	always_comb begin
		next_rdata = 16'h0000;
		if (addr_hit(addr, `FTG_ADDR_LOW_WORD)) begin
			next_rdata = low_word;
		end else if (addr_hit(addr, `FTG_ADDR_HIGH_WORD)) begin
			next_rdata = high_image(out_gate, high_word);
		end else if (addr_hit(addr, `FTG_ADDR_PULL_RANGE)) begin
			next_rdata = range_image(pull_range);
		end
	end

	// Held until the next read, so a slow host may pick it up late
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rdata <= 16'h0000;
		end else if (rd_en) begin
			rdata <= next_rdata;
		end
	end

	// Read strobe echo, one cycle wide
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rvalid <= 1'b0;
		end else begin
			rvalid <= rd_en;
		end
	end

endmodule // ftg_regs

// ===== tb/ftg_host.sv
`timescale 1ns/1ns
module ftg_host (
	input logic mclk,
	output logic wr_en,
	output logic rd_en,
	output logic [7:0] addr,
	output logic [15:0] wdata
);
	initial {wr_en, rd_en, addr, wdata} = '0;
	// One-cycle strobe; data is scrambled once released
	task automatic xfer(logic w, logic [7:0] a, logic [15:0] d);
		if (w && a == 8'h01) repeat (2632) @(posedge mclk);
		@(posedge mclk) #1;
		{wr_en, rd_en, addr, wdata} = {w, !w, a, d};
		@(posedge mclk) #1;
		{wr_en, rd_en, wdata} = {2'h0, ~d};
	endtask
endmodule // ftg_host

// ===== tb/ftg_regs_properties.sv
`timescale 1ns/1ns
module ftg_chk #(
	parameter int WORD_W = 26
) (
	input logic mclk,
	input logic rst,
	input logic wr_en,
	input logic rd_en,
	input logic sw_oe_mode,
	input logic word_update,
	input logic out_enable,
	input logic [7:0] addr,
	input logic [15:0] wdata,
	input logic [15:0] rdata,
	input logic signed [WORD_W-1:0] pull_setting_word
);
	logic hi_wr;
	// The only cause of a commit
	assign hi_wr = wr_en && addr == 8'h01;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	hi_commit_a: assert property (hi_wr |=> word_update) else $error("miss");
	lone_low_a: assert property (!hi_wr |=> !word_update) else $error("extra");
	word_hold_a: assert property (!word_update |-> $stable(pull_setting_word))
		else $error("moved");
	high_field_a: assert property (hi_wr
		|=> pull_setting_word[WORD_W-1:16] == $past(wdata[9:0])) else $error("high");
	unused_zero_a: assert property (rd_en && addr == 8'h01
		|=> rdata[15:11] == 5'h00) else $error("unused");
	low_back_a: assert property (wr_en && addr == 8'h00 ##1 !wr_en ##1 rd_en && !addr
		|=> rdata == $past(wdata, 3)) else $error("low");
	rdata_hold_a: assert property (!rd_en |=> $stable(rdata)) else $error("rdata");
	gate_soft_a: assert property (sw_oe_mode [*3] ##0 hi_wr
		|=> ##1 out_enable == $past(wdata[10], 2)) else $error("gate");
	cover property (word_update && pull_setting_word[WORD_W-1]);
	cover property (out_enable);
	cover property (hi_wr && !sw_oe_mode);
endmodule // ftg_chk
bind ftg_regs ftg_chk #(
	.WORD_W(WORD_W)
) u_ftg_chk (
	.mclk(mclk),
	.rst(rst),
	.wr_en(wr_en),
	.rd_en(rd_en),
	.sw_oe_mode(sw_oe_mode),
	.word_update(word_update),
	.out_enable(out_enable),
	.addr(addr),
	.wdata(wdata),
	.rdata(rdata),
	.pull_setting_word(pull_setting_word)
);

// ===== tb/ftg_regs_tb.sv
`timescale 1ns/1ns
module ftg_regs_tb;
	logic mclk = 1'h0, rst = 1'h1, sw_oe_mode = 1'h1, oe_pin = 1'h0;
	logic wr_en, rd_en, rvalid, word_update, out_enable;
	logic [7:0] addr;
	logic [15:0] wdata, rdata;
	logic signed [25:0] pull_setting_word;
	logic [3:0] pull_range;
	int n_fail = 0, check_count = 0;
	// Clock, design, host
	always #5 mclk = ~mclk;
	ftg_regs u_ftg_regs (
		.mclk(mclk),
		.rst(rst),
		.wr_en(wr_en),
		.rd_en(rd_en),
		.addr(addr),
		.wdata(wdata),
		.sw_oe_mode(sw_oe_mode),
		.oe_pin(oe_pin),
		.rdata(rdata),
		.rvalid(rvalid),
		.pull_setting_word(pull_setting_word),
		.word_update(word_update),
		.pull_range(pull_range),
		.out_enable(out_enable)
	);
	ftg_host u_ftg_host (
		.mclk(mclk),
		.wr_en(wr_en),
		.rd_en(rd_en),
		.addr(addr),
		.wdata(wdata)
	);
	task automatic chk(string s, logic [25:0] e, logic [25:0] g);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic rchk(logic [7:0] a, logic [15:0] e);
		u_ftg_host.xfer(1'h0, a, 16'h0000);
		chk("rvalid", 26'h1, 26'(rvalid));
		chk("rdata", 26'(e), 26'(rdata));
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// Watchdog, well past two paced high writes
	initial begin
		#300000 n_fail++;
		finish_test();
	end
	// Reset for six cycles, then the register sequence
	initial begin
		repeat (6) @(posedge mclk);
		#1 rst = 1'h0;
		chk("word", 26'h0, pull_setting_word);
		chk("oe", 26'h0, 26'(out_enable));
		rchk(8'h01, 16'h0000);
		u_ftg_host.xfer(1'h1, 8'h00, 16'h6666);
		chk("word", 26'h0, pull_setting_word);
		chk("update", 26'h0, 26'(word_update));
		rchk(8'h00, 16'h6666);
		u_ftg_host.xfer(1'h1, 8'h01, 16'hFFFF);
		chk("word", 26'h3FF_6666, pull_setting_word);
		chk("update", 26'h1, 26'(word_update));
		// The driver gate is one register behind the gate bit
		@(posedge mclk) #1;
		chk("update", 26'h0, 26'(word_update));
		chk("oe", 26'h1, 26'(out_enable));
		rchk(8'h01, 16'h07FF);
		u_ftg_host.xfer(1'h1, 8'h02, 16'hFFF5);
		chk("range", 26'h5, 26'(pull_range));
		rchk(8'h02, 16'h0005);
		u_ftg_host.xfer(1'h1, 8'h00, 16'hFFFF);
		chk("word", 26'h3FF_6666, pull_setting_word);
		sw_oe_mode = 1'h0;
		u_ftg_host.xfer(1'h1, 8'h01, 16'h01FF);
		chk("word", 26'h1FF_FFFF, pull_setting_word);
		chk("oe", 26'h0, 26'(out_enable));
		rchk(8'h01, 16'h05FF);
		oe_pin = 1'h1;
		repeat (3) @(posedge mclk);
		#1 chk("oe", 26'h1, 26'(out_enable));
		rchk(8'h05, 16'h0000);
		finish_test();
	end
endmodule // ftg_regs_tb
